/* common/pbas_pkg.sv */
// Operation
// - hold the switch five seconds in normal operation to enter address mode
// - in address mode LEDs show address in binary: first 4, zero 2, error 1
// - address above seven flashes all three LEDs instead of binary
// - each short press in address mode steps to the next address
// - five-second hold in address mode stores the address and leaves the mode
// - fifteen seconds without a press drops the edit and keeps the stored address
// - stepping wraps after seven, a loaded address above seven passes unchanged to node_addr_o
package pbas_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned HOLD_S = 5;
  localparam int unsigned IDLE_S = 15;
  localparam int unsigned FLASH_MS = 250;
  localparam longint unsigned HOLD_CYC = longint'(HOLD_S) * CLK_HZ;
  localparam longint unsigned IDLE_CYC = longint'(IDLE_S) * CLK_HZ;
  localparam longint unsigned FLASH_CYC = longint'(FLASH_MS) * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 32;

  // ----------------------------------------
  // address and reset values
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_MAX = 4'h7;
  localparam logic [3:0] ADDR_RST = 4'h0;

  typedef enum logic [1:0]
  {
    PBAS_NORMAL = 2'b00,
    PBAS_EDIT = 2'b01,
    PBAS_WAIT_REL = 2'b10
  } pbas_state_e;

  typedef struct packed
  {
    logic first;
    logic zero;
    logic err;
  } pbas_leds_s;

endpackage : pbas_pkg

/* logic/pbas_top.sv */
`timescale 1ns/1ps
module pbas_top #(
  parameter logic [31:0] HOLD_CYCLES = 32'(pbas_pkg::HOLD_CYC),
  parameter logic [31:0] IDLE_CYCLES = 32'(pbas_pkg::IDLE_CYC),
  parameter logic [31:0] FLASH_CYCLES = 32'(pbas_pkg::FLASH_CYC)
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic switch_i,
  input wire logic [3:0] stored_addr_i,
  input wire logic stored_valid_i,
  output pbas_pkg::pbas_leds_s leds_o,
  output logic edit_active_o,
  output logic [3:0] node_addr_o,
  output logic store_o
);

  // ----------------------------------------
  // switch synchroniser, three stages
  // ----------------------------------------
  // stage one is read only by stage two, the metastability guard
  logic [2:0] sync_q;
  logic sw_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      sync_q <= 3'h0;
    else if (clk_en_i)
      sync_q <= {sync_q[1:0], switch_i};
  end

  // accept a new level only when stages two and three agree
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      sw_q <= 1'b0;
    else if (clk_en_i && (sync_q[1] == sync_q[2]))
      sw_q <= sync_q[2];
  end

  logic sw_prev_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      sw_prev_q <= 1'b0;
    else if (clk_en_i)
      sw_prev_q <= sw_q;
  end

  // a step is taken on release, so a long hold never also steps
  wire release_ev = !sw_q && sw_prev_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // terminal count of a timer that runs up from zero
  function automatic logic at_last(input logic [31:0] cnt, input logic [31:0] len);
    at_last = (cnt == len - 32'h1);
  endfunction : at_last

  // ----------------------------------------
  // timers
  // ----------------------------------------
  logic [31:0] hold_q;
  logic [31:0] idle_q;
  logic [31:0] flash_q;
  logic blink_q;
  // restarts at the end, so one unbroken hold fires once per period
  wire hold_done = sw_q && at_last(hold_q, HOLD_CYCLES);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      hold_q <= 32'h0;
    else if (clk_en_i)
      hold_q <= (sw_q && !hold_done) ? hold_q + 32'h1 : 32'h0;
  end

  pbas_pkg::pbas_state_e state_q;
  // released cycles only, a held switch never times out
  wire idle_done = at_last(idle_q, IDLE_CYCLES);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      idle_q <= 32'h0;
    else if (clk_en_i)
      idle_q <= (state_q != pbas_pkg::PBAS_EDIT || sw_q) ? 32'h0 : idle_q + 32'h1;
  end

  // flashing is only an indication, its rate is a free choice
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      flash_q <= 32'h0;
      blink_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (at_last(flash_q, FLASH_CYCLES))
      begin
        flash_q <= 32'h0;
        blink_q <= !blink_q;
      end
      else
        flash_q <= flash_q + 32'h1;
    end
  end

  // ----------------------------------------
  // mode control
  // ----------------------------------------
  logic [3:0] edit_q;
  logic [3:0] addr_q;
  logic store_q;

  function automatic logic [3:0] next_addr(input logic [3:0] a);
    next_addr = (a >= pbas_pkg::ADDR_MAX) ? 4'h0 : a + 4'h1;
  endfunction : next_addr

  // save wins over a step; the release after a save lands in normal mode
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      state_q <= pbas_pkg::PBAS_NORMAL;
    else if (clk_en_i)
    begin
      case (state_q)
        pbas_pkg::PBAS_NORMAL:
        begin
          if (hold_done)
            state_q <= pbas_pkg::PBAS_WAIT_REL;
        end
        pbas_pkg::PBAS_EDIT:
        begin
          if (hold_done)
            state_q <= pbas_pkg::PBAS_NORMAL;
          else if (idle_done && !release_ev)
            state_q <= pbas_pkg::PBAS_NORMAL;
        end
        pbas_pkg::PBAS_WAIT_REL:
        begin
          // entry hold must not count as a step
          if (!sw_q)
            state_q <= pbas_pkg::PBAS_EDIT;
        end
        default:
          state_q <= pbas_pkg::PBAS_NORMAL;
      endcase
    end
  end

  // working copy; a timeout simply never writes it back
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      edit_q <= pbas_pkg::ADDR_RST;
    else if (clk_en_i)
    begin
      if (state_q == pbas_pkg::PBAS_NORMAL && hold_done)
        edit_q <= addr_q;
      else if (state_q == pbas_pkg::PBAS_EDIT && !hold_done && release_ev)
        edit_q <= next_addr(edit_q);
    end
  end

  // the store is taken only in normal mode, never over an edit
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      addr_q <= pbas_pkg::ADDR_RST;
    else if (clk_en_i)
    begin
      if (state_q == pbas_pkg::PBAS_EDIT && hold_done)
        addr_q <= edit_q;
      else if (stored_valid_i && state_q == pbas_pkg::PBAS_NORMAL)
        addr_q <= stored_addr_i;
    end
  end

  // one-cycle strobe for whoever persists the address
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      store_q <= 1'b0;
    else if (clk_en_i)
      store_q <= (state_q == pbas_pkg::PBAS_EDIT) && hold_done;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // registered so the pattern never glitches while the state moves
  pbas_pkg::pbas_leds_s leds_q;
  wire in_edit = (state_q != pbas_pkg::PBAS_NORMAL);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      leds_q <= '0;
    else if (clk_en_i)
    begin
      if (!in_edit)
        leds_q <= '0;
      else if (edit_q > pbas_pkg::ADDR_MAX)
        leds_q <= {3{blink_q}};
      else
        leds_q <= edit_q[2:0];
    end
  end

  assign leds_o = leds_q;
  assign edit_active_o = in_edit;
  // four bits wide so a stored value above seven still comes through
  assign node_addr_o = addr_q;
  assign store_o = store_q;

endmodule : pbas_top

/* tb/pbas_operator.sv */
`timescale 1ns/1ps
module pbas_operator (
  input wire logic ref_clk_i,
  output logic sw_o
);
  initial sw_o = 1'b0;
  // ----
  // press for n cycles, then rest past the sync filter
  // ----
  task push(input int n);
    sw_o <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    sw_o <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1;
  endtask : push
endmodule : pbas_operator

/* tb/pbas_top_asserts.sv */
`timescale 1ns/1ps
module pbas_top_asserts (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic [3:0] stored_addr_i,
  input wire logic stored_valid_i,
  input wire logic switch_i,
  input wire pbas_pkg::pbas_leds_s leds_o,
  input wire logic edit_active_o,
  input wire logic [3:0] node_addr_o,
  input wire logic store_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_store_range: assert property (store_o |-> node_addr_o <= 4'h7) else $error("bad save");
  a_store_pulse: assert property (store_o && clk_en_i |=> !store_o) else $error("long save");
  a_store_exit: assert property (store_o |-> ##[0:2] !edit_active_o) else $error("no exit");
  a_entry_hold: assert property ($rose(edit_active_o) |-> $past(switch_i, 12)) else $error("entry");
  a_edit_min: assert property ($rose(edit_active_o) |=> edit_active_o [*8]) else $error("early");
  a_leds_dark: assert property (!edit_active_o && !$past(edit_active_o) |-> leds_o == 3'h0)
    else $error("leds lit");
  a_edit_keep: assert property (edit_active_o && !store_o |-> $stable(node_addr_o))
    else $error("addr moved");
  a_load_norm: assert property (clk_en_i && stored_valid_i && !edit_active_o |=>
    node_addr_o == $past(stored_addr_i)) else $error("no load");
  a_en_freeze: assert property (!clk_en_i |=> $stable(leds_o) && $stable(edit_active_o) &&
    $stable(node_addr_o) && $stable(store_o)) else $error("not frozen");
endmodule : pbas_top_asserts
bind pbas_top pbas_top_asserts u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .clk_en_i(clk_en_i),
  .stored_addr_i(stored_addr_i), .stored_valid_i(stored_valid_i), .switch_i(switch_i),
  .leds_o(leds_o), .edit_active_o(edit_active_o), .node_addr_o(node_addr_o), .store_o(store_o));

/* tb/tb_pushbutton_bus_address_setter.sv */
`timescale 1ns/1ps
module tb_pushbutton_bus_address_setter;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic vld = 1'b0;
  logic en = 1'b1;
  logic sw;
  logic ed;
  logic st;
  logic [3:0] sa = 4'h0;
  logic [3:0] na;
  pbas_pkg::pbas_leds_s leds;
  int fail_count = 0;
  int n_tests = 0;
  int n_store = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  pbas_top #(.HOLD_CYCLES(32'd20), .IDLE_CYCLES(32'd60), .FLASH_CYCLES(32'd4)) uut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(en), .switch_i(sw),
    .stored_addr_i(sa), .stored_valid_i(vld), .leds_o(leds), .edit_active_o(ed),
    .node_addr_o(na), .store_o(st));
  pbas_operator op (.ref_clk_i(ref_clk_i), .sw_o(sw));
  always @(posedge ref_clk_i)
    if (st === 1'b1) n_store++;
  task stop_test;
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task chk(input logic [3:0] g, input logic [3:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task ld(input logic [3:0] a);
    @(posedge ref_clk_i);
    sa <= a;
    vld <= 1'b1;
    @(posedge ref_clk_i);
    vld <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk(na, a);
    op.push(30);
    chk({3'h0, ed}, 4'h1);
  endtask : ld
  // ----
  // scenarios
  // ----
  task t_step;
    ld(4'h5);
    chk({1'b0, leds}, 4'h5);
    op.push(3);
    op.push(3);
    chk({1'b0, leds}, 4'h7);
    op.push(3);
    chk({1'b0, leds}, 4'h0);
    op.push(30);
    chk(na, 4'h0);
    chk({3'h0, ed}, 4'h0);
    chk(n_store[3:0], 4'h1);
    chk({1'b0, leds}, 4'h0);
  endtask : t_step
  task t_idle;
    ld(4'h3);
    op.push(3);
    chk({1'b0, leds}, 4'h4);
    en <= 1'b0;
    repeat (80) @(posedge ref_clk_i);
    #1 chk({3'h0, ed}, 4'h1);
    en <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    #1 chk({3'h0, ed}, 4'h1);
    repeat (30) @(posedge ref_clk_i);
    #1 chk({3'h0, ed}, 4'h0);
    chk(na, 4'h3);
    chk(n_store[3:0], 4'h1);
    op.push(15);
    chk({3'h0, ed}, 4'h0);
  endtask : t_idle
  task t_flash;
    int on;
    int off;
    on = 0;
    off = 0;
    ld(4'h9);
    repeat (16)
    begin
      @(posedge ref_clk_i);
      #1;
      if (leds === 3'h7) on++;
      else if (leds === 3'h0) off++;
    end
    chk({3'h0, on > 0 && off > 0 && on + off == 16}, 4'h1);
    op.push(3);
    chk({1'b0, leds}, 4'h0);
    op.push(30);
    chk(na, 4'h0);
    chk(n_store[3:0], 4'h2);
  endtask : t_flash
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    #1 chk(na, 4'h0);
    t_step;
    t_idle;
    t_flash;
    stop_test;
  end
  // generous: the tests need about 450 cycles
  initial
  begin
    #50us;
    fail_count++;
    stop_test;
  end
endmodule : tb_pushbutton_bus_address_setter
